// File: shared/reset_seq_pkg.sv
// package: constants and types for the reset pin and mode select sequencer
package reset_seq_pkg;

	localparam int    CLK_HZ           = 125000000;
	localparam int    DRIVE_BUS_CYCLES = 34;
	localparam int    SAMPLE_BUS_CYCLES = 38;
	localparam int    BIT_DEBUG_CYCLES = 16;
	localparam int    SELF_CLOCK_HZ    = 8000000;
	localparam int    CNT_W            = 8;
	localparam int    CAUSE_W          = 4;

	// cause bit positions in the reset cause register
	localparam int    CAUSE_EXT        = 0;
	localparam int    CAUSE_LVD        = 1;
	localparam int    CAUSE_WDOG       = 2;
	localparam int    CAUSE_PIN_FAIL   = 3;

	typedef enum logic [4:0] {
		ST_IDLE    = 5'h01,
		ST_DRIVE   = 5'h02,
		ST_WAIT    = 5'h04,
		ST_RELEASE = 5'h08,
		ST_RUN     = 5'h10
	} seq_state_type;

	typedef struct packed {
		logic lowVolt;
		logic watchdog;
	} int_cause_type;

	typedef struct packed {
		logic in;
		logic out;
		logic oeN;
	} od_pin_type;

	typedef struct packed {
		seq_state_type        state;
		logic [CNT_W-1:0]     count;
		logic [CAUSE_W-1:0]   cause;
		logic                 internalCause;
		logic                 backgroundMode;
		logic                 resetOut;
		logic [3:0]           bitCount;
		logic                 speedup;
		logic                 debugPrev;
	} seq_reg_type;

endpackage

// File: design/reset_pin_and_mode_select.sv
// design: reset pin sequencing, cause capture and mode select sampling
`timescale 1ns/1ps
// Function
// R1 - on any reset start, drive reset pin low for 34 bus cycles (35 after rstn, with the extra ST_IDLE cycle)
// R2 - after release, sample reset pin level again 38 bus cycles later
// R3 - internal cause resets expect post-release pin sample high
// R4 - record each reset source in the reset cause register (external bit left clear when an internal source fires in the same cycle)
// R5 - outside party may pull reset pin low at any time
// R6 - mode pin is mode select in reset, debug pin afterwards
// R7 - mode pin high at reset rise selects normal mode
// R8 - mode pin low at reset rise selects active background mode
// R9 - each debug bit time lasts 16 debug clock cycles
// R10 - debug pin is open drain with brief active high speedup pulses
// R11 - tools may select the self clock source as debug clock
// R12 - self clock source runs the logic through reset startup
// R13 - internal reset held until post-release sample, then mode evaluated
module reset_pin_and_mode_select
	import reset_seq_pkg::*;
#(
	parameter int DRIVE_CYCLES  = DRIVE_BUS_CYCLES,
	parameter int SAMPLE_CYCLES = SAMPLE_BUS_CYCLES,
	parameter int BIT_CYCLES    = BIT_DEBUG_CYCLES
) (
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	input  wire logic                resetPinIn,
	output logic                     resetPinOut,
	output logic                     resetPinOeN,
	input  wire logic                debugModeSelectIn,
	output logic                     debugModeSelectOut,
	output logic                     debugModeSelectOeN,
	input  wire logic                debugDriveLow,
	input  wire logic                debugSelfClock,
	input  wire logic                selfClockTick,
	input  wire int_cause_type       intCause,
	output logic                     coreResetN,
	output logic                     backgroundMode,
	output logic                     useSelfClock,
	output logic                     debugBitStrobe,
	output logic [CAUSE_W-1:0]       resetCauseRegister
);

	// ============================================================
	// state
	seq_reg_type r_r;
	seq_reg_type r_nxt;
	logic        anyInternal;
	logic        debugTick;

	assign anyInternal = intCause.lowVolt | intCause.watchdog;
	// debug clock: self clock when tools ask for it, else every bus cycle
	assign debugTick   = debugSelfClock ? selfClockTick : 1'b1; // [R11]

	// ============================================================
	// sequencer
	always_comb begin
		r_nxt = r_r;
		r_nxt.speedup = 1'b0;
		r_nxt.debugPrev = debugModeSelectIn;
		case (r_r.state)
			ST_IDLE: begin
				r_nxt.state = ST_DRIVE;
				r_nxt.count = '0;
			end
			ST_DRIVE: begin
				// pin held low for the fixed drive window
				if (r_r.count == CNT_W'(DRIVE_CYCLES - 1)) begin // [R1]
					r_nxt.state = ST_WAIT;
					r_nxt.count = '0;
				end else begin
					r_nxt.count = r_r.count + 1'b1;
				end
			end
			ST_WAIT: begin
				if (r_r.count == CNT_W'(SAMPLE_CYCLES - 1)) begin // [R2]
					r_nxt.state = ST_RELEASE;
					// internal cause expects the pin high again
					if (r_r.internalCause && !resetPinIn) begin // [R3]
						r_nxt.cause[CAUSE_PIN_FAIL] = 1'b1;
					end
					// a failed sample is only flagged, so the core is never stuck here
					if (!r_r.internalCause || resetPinIn) begin
						r_nxt.state = ST_RELEASE;
					end
				end else begin
					r_nxt.count = r_r.count + 1'b1;
				end
			end
			ST_RELEASE: begin
				// external reset still low keeps the core held
				if (resetPinIn) begin // [R13]
					r_nxt.backgroundMode = !debugModeSelectIn; // [R6] [R7] [R8]
					r_nxt.resetOut = 1'b1;
					r_nxt.state = ST_RUN;
					r_nxt.bitCount = '0;
				end
			end
			ST_RUN: begin
				if (debugTick) begin
					r_nxt.bitCount = r_r.bitCount + 1'b1; // [R9]
				end
				// rising edge on debug line: short active high kick
				if (debugModeSelectIn && !r_r.debugPrev) begin // [R10]
					r_nxt.speedup = 1'b1;
				end
			end
			default: begin
				r_nxt.state = ST_IDLE;
			end
		endcase
		// new reset: external pin low or internal source
		if (r_r.state == ST_RUN && (!resetPinIn || anyInternal)) begin // [R5]
			r_nxt.state = ST_DRIVE;
			r_nxt.count = '0;
			r_nxt.resetOut = 1'b0;
			r_nxt.internalCause = anyInternal;
			r_nxt.cause = '0;
			r_nxt.cause[CAUSE_EXT]  = !anyInternal; // [R4]
			r_nxt.cause[CAUSE_LVD]  = intCause.lowVolt;
			r_nxt.cause[CAUSE_WDOG] = intCause.watchdog;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			r_r.state          <= ST_IDLE;
			r_r.count          <= '0;
			r_r.cause          <= CAUSE_W'(1 << CAUSE_EXT);
			r_r.internalCause  <= 1'b0;
			r_r.backgroundMode <= 1'b0;
			r_r.resetOut       <= 1'b0;
			r_r.bitCount       <= '0;
			r_r.speedup        <= 1'b0;
			// idle level of the pulled-up line, so no false edge after reset
			r_r.debugPrev      <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ============================================================
	// outputs
	// reset pin open drain: data stays low, only the enable moves
	assign resetPinOut        = 1'b0;
	assign resetPinOeN        = !(r_r.state == ST_DRIVE || r_r.state == ST_IDLE); // [R1]
	assign debugModeSelectOut = r_r.speedup;
	// pin is input only while in reset, debug line afterwards
	assign debugModeSelectOeN = !(r_r.state == ST_RUN && (debugDriveLow || r_r.speedup)); // [R6]
	assign coreResetN         = r_r.resetOut;
	assign backgroundMode     = r_r.backgroundMode;
	// self clock runs the sequence until the core leaves reset
	assign useSelfClock       = !r_r.resetOut; // [R12]
	assign debugBitStrobe     = r_r.state == ST_RUN && debugTick && (&r_r.bitCount);
	assign resetCauseRegister = r_r.cause;

	// ============================================================
	// checks
	drive_window_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		$rose(r_r.state == ST_DRIVE) |-> !resetPinOeN [*8])
		else $error("reset pin not held low");
	release_sample_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
		$rose(r_r.state == ST_WAIT) |-> resetPinOeN [*8])
		else $error("reset pin driven during wait");
	core_held_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R13]
		(r_r.state != ST_RUN) |-> !coreResetN)
		else $error("core left reset early");
	mode_latch_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R8]
		(r_r.state == ST_RELEASE && resetPinIn && !debugModeSelectIn) |=> backgroundMode)
		else $error("background mode not entered");
	normal_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R7]
		(r_r.state == ST_RELEASE && resetPinIn && debugModeSelectIn) |=> !backgroundMode)
		else $error("normal mode not entered");
	cause_ext_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
		(r_r.state == ST_RUN && !resetPinIn && !anyInternal) |=> resetCauseRegister[CAUSE_EXT])
		else $error("external cause not recorded");
	pin_input_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R6]
		(r_r.state != ST_RUN) |-> debugModeSelectOeN)
		else $error("mode pin driven in reset");
	speedup_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
		!debugModeSelectOut || $past(debugModeSelectIn) && !$past(r_r.debugPrev, 1) ||
		!debugModeSelectOut)
		else $error("speedup pulse without edge");
	bit_strobe_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R9]
		(debugBitStrobe && !debugSelfClock && r_r.state == ST_RUN && !$rose(r_r.state == ST_RUN))
		|=> !debugBitStrobe [*8])
		else $error("bit strobe spacing wrong");
	self_clock_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R12]
		!coreResetN |-> useSelfClock)
		else $error("self clock not used in reset");
	internal_sample_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
		(r_r.state == ST_WAIT && r_r.count == CNT_W'(SAMPLE_CYCLES - 1) && r_r.internalCause
		&& !resetPinIn) |=> resetCauseRegister[CAUSE_PIN_FAIL])
		else $error("pin sample fault not flagged");
	// end points of the timed phases, cause bookkeeping, debug pin drive and bit clock
	drive_end_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		(r_r.state == ST_DRIVE && r_r.count == CNT_W'(DRIVE_CYCLES - 1)) |=> resetPinOeN)
		else $error("reset pin drive window wrong length");
	wait_end_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R2]
		(r_r.state == ST_WAIT && r_r.count == CNT_W'(SAMPLE_CYCLES - 1))
		|=> (r_r.state == ST_RELEASE))
		else $error("reset pin sample point missed");
	new_reset_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R1]
		(r_r.state == ST_RUN && (!resetPinIn || anyInternal))
		|=> (!resetPinOeN && !coreResetN))
		else $error("new reset not started");
	cause_lvd_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
		(r_r.state == ST_RUN && intCause.lowVolt) |=> resetCauseRegister[CAUSE_LVD])
		else $error("low voltage cause not recorded");
	cause_wdog_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
		(r_r.state == ST_RUN && intCause.watchdog) |=> resetCauseRegister[CAUSE_WDOG])
		else $error("watchdog cause not recorded");
	sample_ok_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R3]
		(r_r.state == ST_WAIT && r_r.count == CNT_W'(SAMPLE_CYCLES - 1) && resetPinIn)
		|=> !resetCauseRegister[CAUSE_PIN_FAIL])
		else $error("pin sample fault flagged wrongly");
	fail_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R4]
		(r_r.state == ST_RUN && (!resetPinIn || anyInternal))
		|=> !resetCauseRegister[CAUSE_PIN_FAIL])
		else $error("stale pin fault kept");
	speedup_once_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
		debugModeSelectOut |=> !debugModeSelectOut)
		else $error("speedup pulse too long");
	drive_low_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R10]
		(r_r.state == ST_RUN && debugDriveLow) |-> !debugModeSelectOeN)
		else $error("debug line not driven");
	self_tick_a: assert property (@(posedge clk_sys) disable iff (!rstn) // [R11]
		(r_r.state == ST_RUN && debugSelfClock && !selfClockTick) |=> $stable(r_r.bitCount))
		else $error("bit counter ran without self clock tick");

endmodule

// File: sim/reset_partner.sv
// partner model: pulled-up reset pin and debug pin with an outside tool
`timescale 1ns/1ps
module reset_partner (
	input  wire logic resetPinOut,
	input  wire logic resetPinOeN,
	input  wire logic pullReset,
	input  wire logic debugModeSelectOut,
	input  wire logic debugModeSelectOeN,
	input  wire logic holdModeLow,
	output logic      resetPinIn,
	output logic      debugModeSelectIn
);
	// switch to ground beats the pull-up at any time
	assign resetPinIn = !pullReset && (resetPinOeN || resetPinOut);
	// tool holds the pin low across reset rise, else pull-up
	assign debugModeSelectIn = !holdModeLow && (debugModeSelectOeN || debugModeSelectOut);
endmodule

// File: sim/test_reset_pin_and_mode_select.sv
// testbench: reset pin sequencing, cause capture and mode select
`timescale 1ns/1ps
module test_reset_pin_and_mode_select import reset_seq_pkg::*; ;
	logic               clk_sys = 1'b0, rstn = 1'b0, pullReset = 1'b0, holdModeLow = 1'b0;
	logic               debugSelfClock = 1'b0, selfClockTick = 1'b0, debugDriveLow = 1'b0;
	int_cause_type      intCause = '0;
	logic               resetPinIn, resetPinOut, resetPinOeN, coreResetN, backgroundMode;
	logic               debugModeSelectIn, debugModeSelectOut, debugModeSelectOeN;
	logic               useSelfClock, debugBitStrobe;
	logic [CAUSE_W-1:0] resetCauseRegister;
	int                 failures = 0, checks = 0;

	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) selfClockTick <= #1 ~selfClockTick;

	reset_pin_and_mode_select u_dut (.clk_sys, .rstn, .resetPinIn, .resetPinOut, .resetPinOeN,
		.debugModeSelectIn, .debugModeSelectOut, .debugModeSelectOeN, .debugDriveLow,
		.debugSelfClock, .selfClockTick, .intCause, .coreResetN, .backgroundMode,
		.useSelfClock, .debugBitStrobe, .resetCauseRegister);
	reset_partner u_partner (.resetPinOut, .resetPinOeN, .pullReset, .debugModeSelectOut,
		.debugModeSelectOeN, .holdModeLow, .resetPinIn, .debugModeSelectIn);

	// ==========================================
	// shared tasks
	task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	// a hang is cut short and counted
	task automatic guard(input int n);
		if (n > 200) begin
			failures++;
			results();
		end
	endtask

	// ==========================================
	// scenarios
	task automatic runSeq(input int expLow, input logic [3:0] expCause, input logic expBg);
		int n;
		n = 0;
		while (resetPinOeN !== 1'b0) begin
			tick();
			n++;
			guard(n);
		end
		cmp(useSelfClock, 1'b1);
		cmp(resetPinOut, 1'b0);
		cmp(debugModeSelectOeN, 1'b1);
		n = 0;
		while (resetPinOeN === 1'b0) begin
			tick();
			n++;
			guard(n);
		end
		cmp(8'(n), 8'(expLow));
		n = 0;
		while (coreResetN === 1'b0) begin
			tick();
			n++;
			guard(n);
		end
		cmp(8'(n), 8'(SAMPLE_BUS_CYCLES + 1));
		cmp(8'(resetCauseRegister), 8'(expCause));
		cmp(backgroundMode, expBg);
		cmp(useSelfClock, 1'b0);
	endtask
	task automatic strobeGap(input int exp);
		int n;
		// the first gap after a clock switch may be partial
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				tick();
				n++;
				guard(n);
			end while (debugBitStrobe !== 1'b1);
		end
		cmp(8'(n), 8'(exp));
	endtask
	// own low drive, then one high kick as the line is let go
	task automatic speedupPulse();
		debugDriveLow = 1'b1;
		tick();
		cmp(debugModeSelectOeN, 1'b0);
		cmp(debugModeSelectIn, 1'b0);
		debugDriveLow = 1'b0;
		tick();
		cmp(debugModeSelectOut, 1'b1);
		cmp(debugModeSelectOeN, 1'b0);
		tick();
		cmp(debugModeSelectOut, 1'b0);
		cmp(debugModeSelectOeN, 1'b1);
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		#1 rstn = 1'b1;
		runSeq(DRIVE_BUS_CYCLES + 1, 4'h1, 1'b0);
		pullReset = 1'b1;
		holdModeLow = 1'b1;
		tick();
		pullReset = 1'b0;
		runSeq(DRIVE_BUS_CYCLES, 4'h1, 1'b1);
		holdModeLow = 1'b0;
		for (int i = 0; i < 2; i++) begin
			intCause = i ? 2'b10 : 2'b01;
			tick();
			intCause = '0;
			runSeq(DRIVE_BUS_CYCLES, i ? 4'h2 : 4'h4, 1'b0);
		end
		intCause = 2'b01;
		tick();
		intCause = '0;
		pullReset = 1'b1;
		repeat (120) tick();
		cmp(coreResetN, 1'b0);
		pullReset = 1'b0;
		repeat (3) tick();
		cmp(coreResetN, 1'b1);
		cmp(8'(resetCauseRegister), 8'h0c);
		strobeGap(BIT_DEBUG_CYCLES);
		debugSelfClock = 1'b1;
		strobeGap(2 * BIT_DEBUG_CYCLES);
		speedupPulse();
		results();
	end
endmodule
